// file: pcg_pkg.sv
// Constants and carrier types for the second port block.
// Assumes a 32-bit AHB-Lite master and word-only accesses.
package pcg_pkg;
	// ****************************************
	// Register indices (byte address = index * 4)
	// ****************************************
	localparam logic [7:0] IDX_INTERRUPT_ENABLE_AND_FLAGS_LO = 8'h0B;	// Interrupt control, low bank
	localparam logic [7:0] IDX_INTERRUPT_ENABLE_AND_FLAGS_HI = 8'h8B;	// Interrupt control, mirror
	localparam logic [7:0] IDX_PORT      = 8'h06;	// Port data latch / pin view
	localparam logic [7:0] IDX_DIR       = 8'h86;	// Direction latch, 1 = input
	localparam logic [7:0] IDX_UNIT      = 8'h17;	// Unit mode and pin control
	localparam logic [7:0] IDX_EVT_STAT  = 8'h40;	// Sticky event status, W1C
	localparam logic [7:0] IDX_EVT_MASK  = 8'h41;	// Event mask
	localparam int         IDX_LSB       = 2;	// Lowest index bit in haddr
	localparam int         IDX_MSB       = 9;	// Highest index bit in haddr

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] RST_INTERRUPT_ENABLE_AND_FLAGS    = 8'h00;
	localparam logic [7:0] RST_DIR       = 8'hFF;
	localparam logic [7:0] RST_LATCH     = 8'h00;
	localparam logic [6:0] RST_UNIT      = 7'h20;
	localparam logic [2:0] RST_EVT       = 3'h0;

	// ****************************************
	// Field positions and encodings
	// ****************************************
	localparam int         EVT_W         = 3;	// Event status width
	localparam int         EVT_PORT      = 0;	// Port change event
	localparam int         EVT_EXT       = 1;	// External pin event
	localparam int         EVT_TMR       = 2;	// Timer zero overflow event
	localparam int         CHG_LO        = 4;	// Lowest change-detect pin
	localparam int         SHARED_BIT    = 3;	// Pin shared with the unit
	localparam logic [3:0] MODE_OFF      = 4'h0;
	localparam logic [1:0] CLS_CAPTURE   = 2'h1;
	localparam logic [1:0] CLS_COMPARE   = 2'h2;
	localparam logic [1:0] CLS_PWM       = 2'h3;

	// Interrupt control fields, bit 7 first
	typedef struct packed {
		logic global_irq_enable;
		logic peripheral_irq_enable;
		logic timer_zero_overflow_enable;
		logic ext_pin_irq_enable;
		logic port_change_irq_enable;
		logic timer_zero_overflow_flag;
		logic ext_pin_irq_flag;
		logic port_change_flag;
	} pcg_interrupt_enable_and_flags_t;

	// Unit control fields, bit 6 first
	typedef struct packed {
		logic       shared_pin_data_bit;
		logic       shared_pin_direction;
		logic       secondary_osc_enable;
		logic [3:0] mode;
	} pcg_unit_t;
endpackage

// file: pcg_port.sv
// Second I/O port: interrupt control, change detect and pin overrides.
// Assumes an AHB-Lite master on sys_clk and pins synchronous to it.
`timescale 1ns/10ps
module pcg_port #(
	parameter int PORT_WIDTH = 8
) (
	input  wire logic                     sys_clk,
	input  wire logic                     rst_n,
	input  wire logic                     hsel,
	input  wire logic [31:0]              haddr,
	input  wire logic [1:0]               htrans,
	input  wire logic                     hwrite,
	input  wire logic [2:0]               hsize,
	input  wire logic [31:0]              hwdata,
	input  wire logic                     hready,
	output logic                          hreadyout,
	output logic                          hresp,
	output logic [31:0]                   hrdata,
	input  wire logic [PORT_WIDTH-1:0]    pin_in,
	output logic [PORT_WIDTH-1:0]         pin_out,
	output logic [PORT_WIDTH-1:0]         pin_oe,
	input  wire logic                     timer_zero_overflow,
	input  wire logic                     ext_pin_event,
	input  wire logic                     unit_out,
	output logic                          capture_level,
	input  wire logic                     sleep_mode,
	output logic                          wake,
	output logic                          irq_request,
	output logic                          evt_irq,
	output pcg_pkg::pcg_unit_t            unit_ctrl
);
	import pcg_pkg::*;

	// ****************************************
	// Elaboration check
	// ****************************************
	if (PORT_WIDTH != 8) begin : g_bad_width
		$error("PORT_WIDTH must be 8");
	end

	// ****************************************
	// Declarations
	// ****************************************
	pcg_interrupt_enable_and_flags_t           interrupt_enable_and_flags;		// Interrupt control register
	pcg_interrupt_enable_and_flags_t           next_interrupt_enable_and_flags;	// Its next value
	pcg_unit_t             unit;		// Unit mode and pin control
	logic [7:0]            dir;		// Direction latch, 1 = input
	logic [7:0]            latch;		// Port data latch
	logic [3:0]            ref_val;	// Reference of the upper pins
	logic [3:0]            miss;		// Per-pin mismatch
	logic                  mismatch;	// Any upper pin mismatch
	logic [7:0]            view;		// Port value seen by a read
	logic [EVT_W-1:0]      evt_stat;	// Sticky event status
	logic [EVT_W-1:0]      evt_mask;	// Event mask
	logic [EVT_W-1:0]      evt_set;	// Event pulses this cycle
	logic                  accept;	// Address phase taken
	logic                  addr_ok;	// Upper address bits are zero
	logic [7:0]            a_idx;		// Index in address phase
	logic                  wr_pend;	// Write data phase pending
	logic [7:0]            wr_idx;	// Index of pending write
	logic [7:0]            read_val;	// Read mux result
	logic                  port_rd;	// Port read in address phase
	logic                  port_wr;	// Port write in data phase
	logic                  wr_interrupt_enable_and_flags;	// Control register write
	logic                  unit_on;	// Unit mode not off
	logic [1:0]            cls;		// Unit mode class
	logic                  capture;	// Capture class selected
	logic                  unit_owns;	// Unit drives the shared pin

	// ****************************************
	// Bus slave decode
	// ****************************************
	assign hreadyout = 1'b1;	// Zero wait states
	assign hresp     = 1'b0;	// Always OKAY
	assign accept    = hsel & htrans[1] & hready;
	assign addr_ok   = (haddr[31:IDX_MSB+1] == 22'h0);
	assign a_idx     = addr_ok ? haddr[IDX_MSB:IDX_LSB] : 8'hFF;
	assign port_rd   = accept & ~hwrite & (a_idx == IDX_PORT);
	assign port_wr   = wr_pend & (wr_idx == IDX_PORT);
	assign wr_interrupt_enable_and_flags = wr_pend & ((wr_idx == IDX_INTERRUPT_ENABLE_AND_FLAGS_LO) | (wr_idx == IDX_INTERRUPT_ENABLE_AND_FLAGS_HI));
	assign unit_ctrl = unit;

	// Capture the write address phase
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_pend <= 1'b0;
			wr_idx  <= 8'h00;
		end else begin
			wr_pend <= accept & hwrite;
			wr_idx  <= a_idx;
		end
	end

	// Read mux; unmapped reads return zero
	always_comb begin
		unique case (a_idx)
			IDX_INTERRUPT_ENABLE_AND_FLAGS_LO, IDX_INTERRUPT_ENABLE_AND_FLAGS_HI: read_val = interrupt_enable_and_flags;
			IDX_PORT:     read_val = view;
			IDX_DIR:      read_val = dir;
			IDX_UNIT:     read_val = {1'b0, pin_in[SHARED_BIT], unit[5:0]};
			IDX_EVT_STAT: read_val = {5'h00, evt_stat};
			IDX_EVT_MASK: read_val = {5'h00, evt_mask};
			default:      read_val = 8'h00;
		endcase
	end

	// Read data registered for the data phase
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			hrdata <= 32'h0000_0000;
		end else if (accept & ~hwrite) begin
			hrdata <= {24'h00_0000, read_val};
		end
	end

	// ****************************************
	// Interrupt control register
	// ****************************************
	// Software write first, hardware set on top so a set wins
	always_comb begin
		next_interrupt_enable_and_flags = interrupt_enable_and_flags;
		if (wr_interrupt_enable_and_flags) begin
			next_interrupt_enable_and_flags = pcg_interrupt_enable_and_flags_t'(hwdata[7:0]);
		end
		next_interrupt_enable_and_flags.timer_zero_overflow_flag |= timer_zero_overflow;
		next_interrupt_enable_and_flags.ext_pin_irq_flag |= ext_pin_event;
		next_interrupt_enable_and_flags.port_change_flag |= mismatch;
	end

	// Control register state
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			interrupt_enable_and_flags <= pcg_interrupt_enable_and_flags_t'(RST_INTERRUPT_ENABLE_AND_FLAGS);
		end else begin
			interrupt_enable_and_flags <= next_interrupt_enable_and_flags;
		end
	end

	// Request to the core and wake from sleep
	assign irq_request = interrupt_enable_and_flags.global_irq_enable &
		((interrupt_enable_and_flags.timer_zero_overflow_enable & interrupt_enable_and_flags.timer_zero_overflow_flag) |
		 (interrupt_enable_and_flags.ext_pin_irq_enable & interrupt_enable_and_flags.ext_pin_irq_flag) |
		 (interrupt_enable_and_flags.port_change_irq_enable & interrupt_enable_and_flags.port_change_flag));
	assign wake = sleep_mode & interrupt_enable_and_flags.port_change_irq_enable & interrupt_enable_and_flags.port_change_flag;

	// ****************************************
	// Port latches and unit control
	// ****************************************
	// Direction, data latch and unit control writes
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			dir   <= RST_DIR;
			latch <= RST_LATCH;
			unit  <= pcg_unit_t'(RST_UNIT);
		end else if (wr_pend) begin
			if (wr_idx == IDX_DIR) begin
				dir <= hwdata[7:0];
			end
			if (port_wr) begin
				latch <= hwdata[7:0];
			end
			if (wr_idx == IDX_UNIT) begin
				unit <= pcg_unit_t'(hwdata[6:0]);
			end
		end
	end

	// Reference refresh on any port access
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ref_val <= 4'h0;
		end else if (port_rd | port_wr) begin
			ref_val <= pin_in[7:CHG_LO];
		end
	end

	// ****************************************
	// Shared pin decode
	// ****************************************
	assign cls       = unit.mode[3:2];
	assign unit_on   = (unit.mode != MODE_OFF);
	assign capture   = (cls == CLS_CAPTURE);
	assign unit_owns = unit_on & ~unit.shared_pin_direction & (cls != 2'h0);
	assign capture_level = capture ? pin_in[SHARED_BIT] : 1'b0;

	// ****************************************
	// Per-pin drive, read view and mismatch
	// ****************************************
	for (genvar i = 0; i < PORT_WIDTH; i++) begin : g_bit
		if (i == 1 || i == 2) begin : g_osc
			// Oscillator pins become inputs
			assign pin_oe[i]  = ~unit.secondary_osc_enable & ~dir[i];
			assign pin_out[i] = latch[i];
			assign view[i]    = pin_in[i];
		end else if (i == SHARED_BIT) begin : g_shared
			// Unit overrides direction and source
			assign pin_oe[i]  = unit_on ? unit_owns : ~dir[i];
			assign pin_out[i] = unit_owns ? (capture ? unit.shared_pin_data_bit : unit_out)
				: latch[i];
			assign view[i]    = !unit_on ? pin_in[i] :
				(~dir[i] ? latch[i] :
				((capture & unit.shared_pin_direction) ? 1'b0 : pin_in[i]));
		end else begin : g_plain
			// Ordinary I/O pin
			assign pin_oe[i]  = ~dir[i];
			assign pin_out[i] = latch[i];
			assign view[i]    = pin_in[i];
		end
		if (i >= CHG_LO) begin : g_chg
			// Output pins never mismatch
			assign miss[i-CHG_LO] = dir[i] & (pin_in[i] ^ ref_val[i-CHG_LO]);
		end
	end
	assign mismatch = |miss;

	// ****************************************
	// Sticky event status and mask
	// ****************************************
	assign evt_set = {timer_zero_overflow, ext_pin_event, mismatch};

	// Write one to clear; a set in the same cycle wins
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			evt_stat <= RST_EVT;
			evt_mask <= RST_EVT;
		end else begin
			if (wr_pend & (wr_idx == IDX_EVT_STAT)) begin
				evt_stat <= (evt_stat & ~hwdata[EVT_W-1:0]) | evt_set;
			end else begin
				evt_stat <= evt_stat | evt_set;
			end
			if (wr_pend & (wr_idx == IDX_EVT_MASK)) begin
				evt_mask <= hwdata[EVT_W-1:0];
			end
		end
	end
	assign evt_irq = |(evt_stat & evt_mask);

	// ****************************************
	// Assertions
	// ****************************************
	property p_flag_on_mismatch;
		@(posedge sys_clk) disable iff (!rst_n) mismatch |=> interrupt_enable_and_flags.port_change_flag;
	endproperty
	a_flag_on_mismatch: assert property (p_flag_on_mismatch) else $error("mismatch did not set flag");

	property p_clear_loses;
		@(posedge sys_clk) disable iff (!rst_n) (mismatch && wr_interrupt_enable_and_flags && !hwdata[0]) |=> interrupt_enable_and_flags.port_change_flag;
	endproperty
	a_clear_loses: assert property (p_clear_loses) else $error("flag cleared during mismatch");

	property p_outputs_excluded;
		@(posedge sys_clk) disable iff (!rst_n) (dir[7:CHG_LO] == 4'h0) |-> !mismatch;
	endproperty
	a_outputs_excluded: assert property (p_outputs_excluded) else $error("output pin mismatched");

	property p_ref_refresh;
		@(posedge sys_clk) disable iff (!rst_n) (port_rd || port_wr) |=> ref_val == $past(pin_in[7:CHG_LO]);
	endproperty
	a_ref_refresh: assert property (p_ref_refresh) else $error("reference not refreshed");

	property p_timer_flag;
		@(posedge sys_clk) disable iff (!rst_n) timer_zero_overflow |=> interrupt_enable_and_flags.timer_zero_overflow_flag;
	endproperty
	a_timer_flag: assert property (p_timer_flag) else $error("timer flag not set");

	property p_request;
		@(posedge sys_clk) disable iff (!rst_n)
			(interrupt_enable_and_flags.global_irq_enable && interrupt_enable_and_flags.port_change_irq_enable && interrupt_enable_and_flags.port_change_flag) |-> irq_request;
	endproperty
	a_request: assert property (p_request) else $error("missing request");

	property p_no_gie;
		@(posedge sys_clk) disable iff (!rst_n) !interrupt_enable_and_flags.global_irq_enable |-> !irq_request;
	endproperty
	a_no_gie: assert property (p_no_gie) else $error("request without global enable");

	property p_wake;
		@(posedge sys_clk) disable iff (!rst_n)
			(sleep_mode && interrupt_enable_and_flags.port_change_irq_enable && interrupt_enable_and_flags.port_change_flag) |-> wake;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake");

	property p_osc_inputs;
		@(posedge sys_clk) disable iff (!rst_n) unit.secondary_osc_enable |-> (pin_oe[2:1] == 2'h0);
	endproperty
	a_osc_inputs: assert property (p_osc_inputs) else $error("oscillator pin driven");

	property p_unit_off;
		@(posedge sys_clk) disable iff (!rst_n)
			(unit.mode == MODE_OFF) |-> (pin_oe[3] == ~dir[3]) && (pin_out[3] == latch[3]);
	endproperty
	a_unit_off: assert property (p_unit_off) else $error("bit 3 not plain");

	property p_cap_read_zero;
		@(posedge sys_clk) disable iff (!rst_n) (capture && unit.shared_pin_direction && dir[3]) |-> !view[3];
	endproperty
	a_cap_read_zero: assert property (p_cap_read_zero) else $error("capture read not zero");

	property p_latch_read;
		@(posedge sys_clk) disable iff (!rst_n) (unit_on && !dir[3]) |-> (view[3] == latch[3]);
	endproperty
	a_latch_read: assert property (p_latch_read) else $error("bit 3 read not latch");

	property p_cap_drive;
		@(posedge sys_clk) disable iff (!rst_n)
			(capture && !unit.shared_pin_direction) |-> pin_oe[3] && (pin_out[3] == unit.shared_pin_data_bit);
	endproperty
	a_cap_drive: assert property (p_cap_drive) else $error("capture drive wrong");

	property p_unit_drive;
		@(posedge sys_clk) disable iff (!rst_n)
			((cls == CLS_PWM || cls == CLS_COMPARE) && !unit.shared_pin_direction) |-> pin_oe[3] && (pin_out[3] == unit_out);
	endproperty
	a_unit_drive: assert property (p_unit_drive) else $error("unit output not on pin");

	c_change: cover property (@(posedge sys_clk) disable iff (!rst_n) mismatch ##1 port_rd ##2 !mismatch);
	c_wake: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(wake));
	c_pwm: cover property (@(posedge sys_clk) disable iff (!rst_n) cls == CLS_PWM && unit_owns);
	c_evt_irq: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(evt_irq));
endmodule

// file: pcg_switch.sv
// Switch model that stands on the pins of the second port.
// Assumes pin drive and pin enable come from pcg_port.
`timescale 1ns/10ps
module pcg_switch (
	input  wire logic [7:0] sw_val,
	input  wire logic [7:0] pin_out,
	input  wire logic [7:0] pin_oe,
	output logic      [7:0] pin_in
);
	// ****************************************
	// Wire resolution
	// ****************************************
	// A driven pin shows the block's level, else the switch holds it
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			pin_in[i] = pin_oe[i] ? pin_out[i] : sw_val[i];
		end
	end
endmodule

// file: tb.sv
// Self-checking bench for the second port block.
// Assumes pcg_pkg, pcg_port and pcg_switch compiled first.
`timescale 1ns/10ps
module tb;
	import pcg_pkg::*;
	// ****************************************
	// Signals
	// ****************************************
	logic        sys_clk = 0, rst_n = 0, hsel = 1, hwrite = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata;
	logic [1:0]  htrans = 0;
	logic [2:0]  hsize = 3'h2;
	logic        hreadyout, hresp, capture_level, wake, irq_request, evt_irq;
	logic        tmr_ev = 0, ext_ev = 0, unit_out = 0, sleep_mode = 0;
	logic [7:0]  sw = 0, pin_in, pin_out, pin_oe;
	pcg_unit_t   unit_ctrl;
	int          n_fail = 0, tests_run = 0;

	always #4 sys_clk = ~sys_clk;	// 125 MHz

	pcg_port uut (.sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
		.timer_zero_overflow(tmr_ev), .ext_pin_event(ext_ev), .unit_out(unit_out),
		.capture_level(capture_level), .sleep_mode(sleep_mode), .wake(wake),
		.irq_request(irq_request), .evt_irq(evt_irq), .unit_ctrl(unit_ctrl));
	pcg_switch sw_model (.sw_val(sw), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));

	// ****************************************
	// Helpers
	// ****************************************
	task automatic final_report();
		$display("checks %0d failures %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			$display("CHECK FAILED %s expected %h seen %h", s, e, g);
			n_fail++;
		end
	endtask
	function automatic logic [31:0] ad(input logic [7:0] idx);
		return {22'h0, idx, 2'h0};
	endfunction
	// Bounded wait for the slave's ready
	task automatic rdy();
		int i;
		i = 0;
		do begin
			@(posedge sys_clk);
			i++;
		end while (hreadyout !== 1'b1 && i < 16);
		if (hreadyout !== 1'b1) begin
			n_fail++;
			final_report();
		end
	endtask
	// One single word transfer, address then data phase
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		rdy();
		htrans <= 2'h0;
		hwdata <= d;
		rdy();
		r = hrdata;
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask
	// Masked read compare, retried a few times for synchronised pins
	task automatic rc(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e, input string s);
		logic [31:0] r;
		int i;
		i = 0;
		do begin
			bus(1'b0, a, 32'h0, r);
			i++;
		end while ((r & m) !== e && i < 6);
		chk(s, e, r & m);
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic pulse(input int k);
		if (k == 2) tmr_ev <= 1'b1;
		else ext_ev <= 1'b1;
		@(posedge sys_clk);
		tmr_ev <= 1'b0;
		ext_ev <= 1'b0;
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset();
		chk("hresp", 32'h0, {31'h0, hresp});
		chk("hreadyout", 32'h1, {31'h0, hreadyout});
		rc(ad(IDX_INTERRUPT_ENABLE_AND_FLAGS_LO), 32'hFF, 32'h00, "interrupt_enable_and_flags reset");
		rc(ad(IDX_DIR), 32'hFF, 32'hFF, "dir reset");
		rc(ad(IDX_UNIT), 32'h7F, 32'h20, "unit reset");
		rc(ad(IDX_EVT_STAT), 32'h7, 32'h0, "stat reset");
		wr(32'h300, 32'h5A);
		rc(32'h300, 32'hFFFFFFFF, 32'h0, "unmapped");
	endtask
	task automatic t_mirror();
		wr(ad(IDX_INTERRUPT_ENABLE_AND_FLAGS_LO), 32'h08);
		rc(ad(IDX_INTERRUPT_ENABLE_AND_FLAGS_HI), 32'hFF, 32'h08, "mirror");
		wr(ad(IDX_INTERRUPT_ENABLE_AND_FLAGS_HI), 32'h00);
		rc(ad(IDX_INTERRUPT_ENABLE_AND_FLAGS_LO), 32'hFF, 32'h00, "mirror back");
	endtask
	task automatic t_change();
		rc(ad(IDX_PORT), 32'hFF, 32'h00, "port idle");
		sw <= 8'h20;
		rc(ad(IDX_INTERRUPT_ENABLE_AND_FLAGS_LO), 32'h01, 32'h01, "chg flag");
		wr(ad(IDX_INTERRUPT_ENABLE_AND_FLAGS_LO), 32'h00);
		rc(ad(IDX_INTERRUPT_ENABLE_AND_FLAGS_LO), 32'h01, 32'h01, "chg persist");
		rc(ad(IDX_PORT), 32'hFF, 32'h20, "port pins");
		wr(ad(IDX_INTERRUPT_ENABLE_AND_FLAGS_LO), 32'h00);
		rc(ad(IDX_INTERRUPT_ENABLE_AND_FLAGS_LO), 32'h01, 32'h00, "read ends");
		sw <= 8'hA0;
		idle(4);
		wr(ad(IDX_PORT), 32'h00);
		wr(ad(IDX_INTERRUPT_ENABLE_AND_FLAGS_LO), 32'h00);
		idle(4);
		rc(ad(IDX_INTERRUPT_ENABLE_AND_FLAGS_LO), 32'h01, 32'h00, "write ends");
		// Pin 6 driven high as output must not count as a change
		wr(ad(IDX_DIR), 32'hBF);
		wr(ad(IDX_PORT), 32'h40);
		wr(ad(IDX_INTERRUPT_ENABLE_AND_FLAGS_LO), 32'h00);
		idle(4);
		rc(ad(IDX_INTERRUPT_ENABLE_AND_FLAGS_LO), 32'h01, 32'h00, "output excluded");
		wr(ad(IDX_DIR), 32'hFF);
		rc(ad(IDX_PORT), 32'hFF, 32'hA0, "port back");
	endtask
	task automatic t_irq();
		logic [7:0] v;
		for (int k = 0; k < 3; k++) begin
			v = 8'h80 | (8'h08 << k) | (8'h01 << k);
			wr(ad(IDX_INTERRUPT_ENABLE_AND_FLAGS_LO), {24'h0, v});
			idle(1);
			chk("irq on", 32'h1, {31'h0, irq_request});
			wr(ad(IDX_INTERRUPT_ENABLE_AND_FLAGS_LO), {24'h0, v & 8'h7F});
			idle(1);
			chk("irq no gie", 32'h0, {31'h0, irq_request});
			wr(ad(IDX_INTERRUPT_ENABLE_AND_FLAGS_LO), {24'h0, 8'h80 | (8'h01 << k)});
			idle(1);
			chk("irq no en", 32'h0, {31'h0, irq_request});
		end
		wr(ad(IDX_INTERRUPT_ENABLE_AND_FLAGS_LO), 32'h00);
		pulse(2);
		rc(ad(IDX_INTERRUPT_ENABLE_AND_FLAGS_LO), 32'h07, 32'h04, "tmr flag");
		pulse(1);
		rc(ad(IDX_INTERRUPT_ENABLE_AND_FLAGS_LO), 32'h07, 32'h06, "ext flag");
		wr(ad(IDX_INTERRUPT_ENABLE_AND_FLAGS_LO), 32'h00);
	endtask
	task automatic t_wake();
		int i;
		wr(ad(IDX_INTERRUPT_ENABLE_AND_FLAGS_LO), 32'h00);
		wr(ad(IDX_INTERRUPT_ENABLE_AND_FLAGS_LO), 32'h08);
		sleep_mode <= 1'b1;
		sw <= 8'hB0;
		i = 0;
		while (wake !== 1'b1 && i < 16) begin
			@(posedge sys_clk);
			i++;
		end
		chk("wake", 32'h1, {31'h0, wake});
		rc(ad(IDX_PORT), 32'hF0, 32'hB0, "port wake");
		wr(ad(IDX_INTERRUPT_ENABLE_AND_FLAGS_LO), 32'h00);
		idle(1);
		chk("wake off", 32'h0, {31'h0, wake});
		sleep_mode <= 1'b0;
	endtask
	task automatic t_evt();
		wr(ad(IDX_EVT_MASK), 32'h2);
		pulse(1);
		idle(1);
		chk("evt irq", 32'h1, {31'h0, evt_irq});
		wr(ad(IDX_EVT_STAT), 32'h0);
		rc(ad(IDX_EVT_STAT), 32'h2, 32'h2, "stat sticky");
		wr(ad(IDX_EVT_MASK), 32'h0);
		idle(1);
		chk("evt masked", 32'h0, {31'h0, evt_irq});
		wr(ad(IDX_EVT_MASK), 32'h2);
		wr(ad(IDX_EVT_STAT), 32'h2);
		idle(1);
		chk("evt cleared", 32'h0, {31'h0, evt_irq});
		rc(ad(IDX_EVT_STAT), 32'h2, 32'h0, "stat w1c");
	endtask
	task automatic t_osc();
		wr(ad(IDX_DIR), 32'h00);
		wr(ad(IDX_PORT), 32'hFF);
		idle(1);
		chk("oe all", 32'hFF, {24'h0, pin_oe});
		wr(ad(IDX_UNIT), 32'h30);
		idle(1);
		chk("oe osc", 32'hF9, {24'h0, pin_oe});
		wr(ad(IDX_UNIT), 32'h20);
		idle(1);
		chk("oe osc off", 32'hFF, {24'h0, pin_oe});
	endtask
	task automatic t_shared();
		rc(ad(IDX_PORT), 32'h08, 32'h08, "off io hi");
		wr(ad(IDX_PORT), 32'hF7);
		rc(ad(IDX_PORT), 32'h08, 32'h00, "off io lo");
		wr(ad(IDX_DIR), 32'h08);
		wr(ad(IDX_UNIT), 32'h44);
		idle(1);
		chk("own oe", 32'h1, {31'h0, pin_oe[3]});
		chk("own drv", 32'h1, {31'h0, pin_out[3]});
		chk("cap lvl", 32'h1, {31'h0, capture_level});
		chk("unit copy", 32'h44, {25'h0, unit_ctrl});
		rc(ad(IDX_UNIT), 32'h40, 32'h40, "data bit pin");
		wr(ad(IDX_UNIT), 32'h04);
		wr(ad(IDX_PORT), 32'h08);
		idle(1);
		chk("latch only", 32'h0, {31'h0, pin_out[3]});
		wr(ad(IDX_DIR), 32'h00);
		rc(ad(IDX_PORT), 32'h08, 32'h08, "read latch");
		for (int m = 0; m < 2; m++) begin
			wr(ad(IDX_UNIT), m ? 32'h0C : 32'h08);
			unit_out <= 1'b1;
			@(posedge sys_clk);
			chk("unit hi", 32'h1, {31'h0, pin_out[3]});
			unit_out <= 1'b0;
			@(posedge sys_clk);
			chk("unit lo", 32'h0, {31'h0, pin_out[3]});
		end
		wr(ad(IDX_DIR), 32'h08);
		wr(ad(IDX_UNIT), 32'h24);
		sw <= 8'h08;
		@(posedge sys_clk);
		chk("cap oe", 32'h0, {31'h0, pin_oe[3]});
		chk("cap in", 32'h1, {31'h0, capture_level});
		rc(ad(IDX_PORT), 32'h08, 32'h00, "cap reads 0");
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (5) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		t_reset();
		t_mirror();
		t_change();
		t_irq();
		t_wake();
		t_evt();
		t_osc();
		t_shared();
		final_report();
	end
endmodule
